// ### nand_host_pkg.sv
// Purpose: constants shared by the serial nand host sequencer
// Assumes: spi mode 0, msb first, x1 transfers only
// Notes:   command opcodes and feature values are the device's own encodings
package nand_host_pkg;
    // ==========================================================
    // command opcodes
    localparam logic [7:0] OP_WREN     = 8'h06;
    localparam logic [7:0] OP_LOAD     = 8'h02;
    localparam logic [7:0] OP_LOAD_RND = 8'h84;
    localparam logic [7:0] OP_EXEC     = 8'h10;
    localparam logic [7:0] OP_PREAD    = 8'h13;
    localparam logic [7:0] OP_ERASE    = 8'hd8;
    localparam logic [7:0] OP_GETF     = 8'h0f;
    localparam logic [7:0] OP_SETF     = 8'h1f;
    localparam logic [7:0] OP_RDID     = 8'h9f;
    // ==========================================================
    // feature addresses and values
    localparam logic [7:0] FA_PROT     = 8'ha0;
    localparam logic [7:0] FA_CFG      = 8'hb0;
    localparam logic [7:0] FA_STAT     = 8'hc0;
    localparam logic [7:0] CFG_OTP_EN  = 8'h40;
    localparam logic [7:0] CFG_OTP_LCK = 8'hc0;
    localparam logic [7:0] CFG_LEAVE   = 8'h00;
    localparam logic [7:0] CFG_ECC_BIT = 8'h10;
    localparam logic [7:0] PROT_CLEAR  = 8'h00;
    localparam int         STAT_BUSY   = 0;
    // ==========================================================
    // host register map (word index on the plain port)
    localparam logic [3:0] A_CMD    = 4'h0;
    localparam logic [3:0] A_ROW    = 4'h1;
    localparam logic [3:0] A_COL    = 4'h2;
    localparam logic [3:0] A_WDATA  = 4'h3;
    localparam logic [3:0] A_STATUS = 4'h4;
    localparam logic [3:0] A_RDATA  = 4'h5;
    localparam logic [3:0] A_ID_LO  = 4'h6;
    localparam logic [3:0] A_ID_HI  = 4'h7;
    localparam logic [3:0] A_CFG    = 4'h8;
    // command codes written to A_CMD
    localparam logic [3:0] C_LOAD   = 4'h1;
    localparam logic [3:0] C_LOADR  = 4'h2;
    localparam logic [3:0] C_EXEC   = 4'h3;
    localparam logic [3:0] C_ERASE  = 4'h4;
    localparam logic [3:0] C_PREAD  = 4'h5;
    localparam logic [3:0] C_RDID   = 4'h6;
    localparam logic [3:0] C_OTPEN  = 4'h7;
    localparam logic [3:0] C_OTPLCK = 4'h8;
    localparam logic [3:0] C_OTPOFF = 4'h9;
    localparam logic [3:0] C_STREAM = 4'ha;
    // ==========================================================
    // timing
    localparam int CLK_MHZ      = 20;
    localparam int PWRUP_US     = 1000;
    localparam int PWRUP_CYC    = PWRUP_US * CLK_MHZ;
    localparam int PAGE_BYTES   = 2112;
    localparam int ID_BYTES     = 5;
    localparam int SCK_HALF     = 2;
endpackage : nand_host_pkg

// ### nand_host.sv
// Purpose: host-side sequencer driving a serial nand flash over x1 spi
// Assumes: software issues one command at a time and waits for idle
// Notes:   sck is made here by a divider; data bytes stream through A_WDATA
// Operation
// - load: 4 dummy bits then 12-bit column
// - at most four partial programs per page
// - execute: 8 dummy bits, 16-bit row
// - execute after load, then wait busy
// - random load keeps other cache bytes
// - move: page read, enable, execute
// - erase: 8 dummy bits, 16-bit row
// - poll status until operation completes
// - id command, zero address, five bytes
// - no access until 1ms after power-up
// - otp enable bit steers reads, programs
// - otp program: clear protect, enable, load
// - otp lock: enable and protect, execute
// - ecc bit variants keep correction on; host ORs in the ecc bit only while A_CFG bit 0 is set
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module nand_host #(
    parameter int PWRUP_CYCLES = nand_host_pkg::PWRUP_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             cs_n,
    output logic             sck,
    output logic             mosi,
    input  wire logic        miso,
    output logic             pause_n,
    output logic             wp_n
);
    if (PWRUP_CYCLES < 1) begin : g_pwrup_chk
        $error("PWRUP_CYCLES must be positive");
    end

    // ==========================================================
    // state
    typedef enum logic [6:0] {
        S_PWRUP = 7'h01, S_IDLE = 7'h02, S_SHIFT = 7'h04, S_GAP = 7'h08,
        S_POLL  = 7'h10, S_STRM = 7'h20, S_DONE = 7'h40
    } st_e;

    typedef struct packed {
        st_e         st;
        logic [31:0] rdata;
        logic        cs_n;
        logic        sck;
        logic        mosi;
        logic [15:0] row;
        logic [11:0] col;
        logic [7:0]  wbyte;
        logic        wbyte_v;
        logic [7:0]  rbyte;
        logic [39:0] id;
        logic        ecc;
        logic [3:0]  cmd;
        logic [2:0]  step;
        logic [39:0] sh;
        logic [5:0]  nbits;
        logic [39:0] rx;
        logic        rx_on;
        logic [1:0]  div;
        logic [11:0] cnt;
        logic [24:0] pw;
        logic        stop;
        logic        pins;
        logic [2:0]  nprog;
    } st_s;

    st_s  q_r, q_nxt;
    logic miso_s1_r, miso_s2_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    // ==========================================================
    // frame builder: returns opcode plus address bits, and bit count
    function automatic logic [45:0] frame(input logic [3:0] cmd, input logic [2:0] step,
                                          input logic [15:0] row, input logic [11:0] col,
                                          input logic ecc);
        logic [7:0] e;
        e = ecc ? nand_host_pkg::CFG_ECC_BIT : 8'h00;
        frame = {6'd8, nand_host_pkg::OP_WREN, 32'h0};
        case (cmd)
            nand_host_pkg::C_LOAD, nand_host_pkg::C_LOADR: begin
                if (step == 3'd1)
                    frame = {6'd24, (cmd == nand_host_pkg::C_LOAD) ? nand_host_pkg::OP_LOAD
                             : nand_host_pkg::OP_LOAD_RND, 4'h0, col, 16'h0};
            end
            nand_host_pkg::C_EXEC, nand_host_pkg::C_OTPLCK: begin
                if (step == 3'd3 || (cmd == nand_host_pkg::C_EXEC && step == 3'd1))
                    frame = {6'd32, nand_host_pkg::OP_EXEC, 8'h00, row, 8'h0};
                else if (cmd == nand_host_pkg::C_OTPLCK && step == 3'd0)
                    frame = {6'd24, nand_host_pkg::OP_SETF, nand_host_pkg::FA_PROT,
                             nand_host_pkg::PROT_CLEAR, 16'h0};
                else if (step == 3'd1)
                    frame = {6'd24, nand_host_pkg::OP_SETF, nand_host_pkg::FA_CFG,
                             nand_host_pkg::CFG_OTP_LCK | e, 16'h0};
            end
            nand_host_pkg::C_ERASE: begin
                if (step == 3'd1)
                    frame = {6'd32, nand_host_pkg::OP_ERASE, 8'h00, row, 8'h0};
            end
            // page read fills the cache for a move
            nand_host_pkg::C_PREAD:
                frame = {6'd32, nand_host_pkg::OP_PREAD, 8'h00, row, 8'h0};
            nand_host_pkg::C_RDID:
                // opcode, zero address, five bytes back
                frame = {6'd56, nand_host_pkg::OP_RDID, 8'h00, 24'h0};
            nand_host_pkg::C_OTPEN: begin
                if (step == 3'd0)
                    frame = {6'd24, nand_host_pkg::OP_SETF, nand_host_pkg::FA_PROT,
                             nand_host_pkg::PROT_CLEAR, 16'h0};
                else
                    frame = {6'd24, nand_host_pkg::OP_SETF, nand_host_pkg::FA_CFG,
                             nand_host_pkg::CFG_OTP_EN | e, 16'h0};
            end
            default:
                // leaving otp mode clears the enable bit
                frame = {6'd24, nand_host_pkg::OP_SETF, nand_host_pkg::FA_CFG,
                         nand_host_pkg::CFG_LEAVE | e, 16'h0};
        endcase
    endfunction : frame

    // last step index of each command
    function automatic logic [2:0] last_step(input logic [3:0] cmd);
        case (cmd)
            nand_host_pkg::C_LOAD, nand_host_pkg::C_LOADR,
            nand_host_pkg::C_EXEC, nand_host_pkg::C_ERASE,
            nand_host_pkg::C_OTPEN:                        last_step = 3'd1;
            nand_host_pkg::C_OTPLCK:                       last_step = 3'd3;
            default:                                       last_step = 3'd0;
        endcase
    endfunction : last_step

    // commands that change the array, and page read, end with a status poll
    function automatic logic needs_poll(input logic [3:0] cmd);
        needs_poll = (cmd == nand_host_pkg::C_EXEC) || (cmd == nand_host_pkg::C_ERASE) ||
                     (cmd == nand_host_pkg::C_OTPLCK) || (cmd == nand_host_pkg::C_PREAD);
    endfunction : needs_poll

    logic [45:0] fr;
    logic        fall;

    always_comb begin
        q_nxt = q_r;
        fr    = frame(q_r.cmd, q_r.step, q_r.row, q_r.col, q_r.ecc);
        q_nxt.pins = 1'b1;
        fall  = 1'b0;
        if (q_r.div == 2'(nand_host_pkg::SCK_HALF - 1)) begin
            fall = q_r.sck;
        end

        // software writes
        if (wr) begin
            if (addr == nand_host_pkg::A_ROW) begin
                q_nxt.row = wdata[15:0];
                if (wdata[15:0] != q_r.row)
                    q_nxt.nprog = 3'd0;
            end else if (addr == nand_host_pkg::A_COL) begin
                q_nxt.col = wdata[11:0];
            end else if (addr == nand_host_pkg::A_CFG) begin
                q_nxt.ecc = wdata[0];
            end else if (addr == nand_host_pkg::A_WDATA) begin
                q_nxt.wbyte   = wdata[7:0];
                q_nxt.wbyte_v = 1'b1;
            end
        end
        // software reads, data one cycle later
        q_nxt.rdata = 32'h0;
        if (rd) begin
            if (addr == nand_host_pkg::A_STATUS) begin
                q_nxt.rdata = {24'h0, 1'b0, ~q_r.wbyte_v, q_r.st == st_e'(S_STRM),
                               q_r.st == st_e'(S_IDLE), 4'h0};
            end else if (addr == nand_host_pkg::A_RDATA) begin
                q_nxt.rdata = {24'h0, q_r.rbyte};
            end else if (addr == nand_host_pkg::A_ID_LO) begin
                q_nxt.rdata = q_r.id[39:8];
            end else if (addr == nand_host_pkg::A_ID_HI) begin
                q_nxt.rdata = {24'h0, q_r.id[7:0]};
            end
        end

        case (q_r.st)
            S_PWRUP: begin
                // hold off until power-up window passes
                q_nxt.pw = q_r.pw + 25'h1;
                if (q_r.pw == 25'(PWRUP_CYCLES - 1))
                    q_nxt.st = S_IDLE;
            end
            S_IDLE: begin
                // a fifth execute on one row is refused
                if (wr && addr == nand_host_pkg::A_CMD && wdata[3:0] != 4'h0 &&
                    wdata[3:0] != nand_host_pkg::C_STREAM &&
                    !(wdata[3:0] == nand_host_pkg::C_EXEC && q_r.nprog == 3'd4)) begin
                    q_nxt.cmd   = wdata[3:0];
                    q_nxt.step  = 3'd0;
                    q_nxt.st    = S_GAP;
                    if (wdata[3:0] == nand_host_pkg::C_EXEC)
                        q_nxt.nprog = q_r.nprog + 3'd1;
                end
            end
            S_GAP: begin
                // load one frame; first step of program and erase is write enable
                // write enable before program or erase
                q_nxt.sh    = fr[39:0];
                q_nxt.nbits = fr[45:40];
                q_nxt.rx_on = (q_r.cmd == nand_host_pkg::C_RDID);
                q_nxt.cs_n  = 1'b0;
                q_nxt.div   = 2'd0;
                q_nxt.mosi  = fr[39];
                q_nxt.st    = S_SHIFT;
            end
            S_SHIFT: begin
                q_nxt.div = q_r.div + 2'd1;
                if (q_r.div == 2'(nand_host_pkg::SCK_HALF - 1)) begin
                    q_nxt.div = 2'd0;
                    q_nxt.sck = ~q_r.sck;
                end
                // the synchroniser delays miso two cycles, so the bit seen at the
                // sck rise is only available here, just before the next fall
                if (fall)
                    q_nxt.rx = {q_r.rx[38:0], miso_s2_r};
                if (fall) begin
                    q_nxt.sh    = {q_r.sh[38:0], 1'b0};
                    q_nxt.mosi  = q_r.sh[38];
                    q_nxt.nbits = q_r.nbits - 6'd1;
                    if (q_r.nbits == 6'd1) begin
                        if ((q_r.cmd == nand_host_pkg::C_LOAD ||
                             q_r.cmd == nand_host_pkg::C_LOADR) && q_r.step == 3'd1) begin
                            // stream up to 2112 data bytes
                            q_nxt.cnt = 12'h0;
                            q_nxt.st  = S_STRM;
                        end else begin
                            q_nxt.cs_n = 1'b1;
                            q_nxt.st   = S_DONE;
                        end
                    end
                end
            end
            S_STRM: begin
                // a stop request waits until the last byte has left the shifter
                if (wr && addr == nand_host_pkg::A_CMD && wdata[3:0] == nand_host_pkg::C_STREAM)
                    q_nxt.stop = 1'b1;
                // random load only rewrites streamed columns
                if (q_r.nbits == 6'd0 && q_r.wbyte_v) begin
                    // a byte past a full page is dropped, freeing the slot
                    q_nxt.wbyte_v = wr && addr == nand_host_pkg::A_WDATA;
                    if (q_r.cnt != 12'(nand_host_pkg::PAGE_BYTES)) begin
                        q_nxt.sh    = {q_r.wbyte, 32'h0};
                        q_nxt.mosi  = q_r.wbyte[7];
                        q_nxt.nbits = 6'd8;
                        q_nxt.cnt   = q_r.cnt + 12'h1;
                    end
                end else if (q_r.nbits != 6'd0) begin
                    q_nxt.div = q_r.div + 2'd1;
                    if (q_r.div == 2'(nand_host_pkg::SCK_HALF - 1)) begin
                        q_nxt.div = 2'd0;
                        q_nxt.sck = ~q_r.sck;
                    end
                    if (fall) begin
                        q_nxt.sh    = {q_r.sh[38:0], 1'b0};
                        q_nxt.mosi  = q_r.sh[38];
                        q_nxt.nbits = q_r.nbits - 6'd1;
                    end
                end else if (q_r.stop) begin
                    q_nxt.stop = 1'b0;
                    q_nxt.cs_n = 1'b1;
                    q_nxt.st   = S_IDLE;
                end
            end
            S_DONE: begin
                if (q_r.rx_on)
                    q_nxt.id = q_r.rx;
                if (q_r.step != last_step(q_r.cmd)) begin
                    q_nxt.step = q_r.step + 3'd1;
                    q_nxt.st   = S_GAP;
                end else if (needs_poll(q_r.cmd)) begin
                    q_nxt.cmd  = 4'h0;
                    q_nxt.st   = S_POLL;
                end else begin
                    q_nxt.st   = S_IDLE;
                end
            end
            S_POLL: begin
                // reuse the shifter for a get-feature of the status byte
                q_nxt.sh    = {nand_host_pkg::OP_GETF, nand_host_pkg::FA_STAT, 24'h0};
                q_nxt.nbits = 6'd24;
                q_nxt.mosi  = nand_host_pkg::OP_GETF[7];
                q_nxt.cs_n  = 1'b0;
                q_nxt.div   = 2'd0;
                q_nxt.rx_on = 1'b0;
                q_nxt.cmd   = nand_host_pkg::C_STREAM;
                q_nxt.st    = S_SHIFT;
            end
            default: q_nxt.st = S_IDLE;
        endcase

        // after a poll frame, decide whether to poll again
        if (q_r.st == S_DONE && q_r.cmd == nand_host_pkg::C_STREAM) begin
            q_nxt.rbyte = q_r.rx[7:0];
            // wait while the device reports busy
            q_nxt.st    = q_r.rx[nand_host_pkg::STAT_BUSY] ? S_POLL : S_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_r      <= '0;
            q_r.st   <= S_PWRUP;
            q_r.cs_n <= 1'b1;
            q_r.ecc  <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rdata   = q_r.rdata;
    assign cs_n    = q_r.cs_n;
    assign sck     = q_r.sck;
    assign mosi    = q_r.mosi;
    // host holds pause and write protect low during reset, then keeps both released from the first cycle after
    assign pause_n = q_r.pins;
    assign wp_n    = q_r.pins;

    // ==========================================================
    // checks
    // no chip select during power-up
    pwrup_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_PWRUP |-> cs_n) else $error("chip select during power-up");
    // data stream capped at one page
    page_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.cnt <= 12'(nand_host_pkg::PAGE_BYTES)) else $error("more than a page streamed");
    // poll starts a frame next cycle
    poll_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_POLL |=> !cs_n && q_r.nbits == 6'd24) else $error("poll frame missing");
    wren_first_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_GAP && q_r.step == 3'd0 && (q_r.cmd == nand_host_pkg::C_EXEC ||
        q_r.cmd == nand_host_pkg::C_ERASE) |=> q_r.sh[39:32] == nand_host_pkg::OP_WREN)
        else $error("program without write enable");
    exec_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_GAP && q_r.cmd == nand_host_pkg::C_EXEC && q_r.step == 3'd1
        |=> q_r.nbits == 6'd32) else $error("execute length wrong");
    load_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_GAP && q_r.cmd == nand_host_pkg::C_LOAD && q_r.step == 3'd1
        |=> q_r.nbits == 6'd24) else $error("load header length wrong");
    id_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_GAP && q_r.cmd == nand_host_pkg::C_RDID |=> q_r.nbits == 6'd56)
        else $error("id frame length wrong");
    // chip select stays low while shifting
    cs_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        q_r.st == S_SHIFT && q_r.nbits > 6'd1 |=> !cs_n) else $error("frame broken");
    erase_cov: cover property (@(posedge sys_clk) q_r.cmd == nand_host_pkg::C_ERASE && q_r.st == S_DONE);
    poll_cov:  cover property (@(posedge sys_clk) q_r.st == S_POLL);
    strm_cov:  cover property (@(posedge sys_clk) q_r.st == S_STRM && q_r.nbits == 6'd8);
endmodule : nand_host

// ### nand_flash_model.sv
// Purpose: behavioural serial nand device facing the host sequencer
// Assumes: spi mode 0, x1 transfers, msb first
// Notes:   keeps observable fields only; no array is modelled
`timescale 1ns/1ps
module nand_flash_model #(
    parameter int          BUSY_NS = 20000,
    parameter logic [39:0] ID_SEQ  = 40'h5aa53c3c3c // arbitrary identity bytes
) (
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso,
    input  wire logic pause_n,
    input  wire logic wp_n
);
    logic [7:0]  sh, op, fa, cfg, prot;
    logic [11:0] ld_col;
    logic [15:0] row, exec_row, erase_row;
    logic [39:0] tx;
    logic        write_enable_latch, loading, otp_lock;
    int          nb, nbyte, ld_cnt, n_raw, n_exec, n_erase;
    realtime     busy_end;
    // protection starts set so that clearing it can be seen
    initial begin
        cfg      = 8'h10;
        prot     = 8'hff;
        write_enable_latch = 1'b0;
        otp_lock = 1'b0;
        miso     = 1'b0;
        busy_end = 0;
    end
    // ==========================================================
    // frame decode on sck rise
    always @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            nb = 0;
            nbyte = 0;
            loading = 1'b0;
        end else if (pause_n && wp_n) begin
            sh = {sh[6:0], mosi};
            nb++;
            if (nb == 8) begin
                nb = 0;
                if (nbyte == 0) op = sh;
                if (op == 8'h06) write_enable_latch = 1'b1;
                if (nbyte == 1) fa = sh;
                if (nbyte == 2) row[15:8] = sh;
                if ((op == 8'h02 || op == 8'h84) && nbyte == 2 && write_enable_latch) begin
                    ld_col = {fa[3:0], sh};
                    ld_cnt = 0;
                    n_raw = 0;
                    loading = 1'b1;
                end
                // cache keeps 2112 bytes at most
                if (loading && nbyte > 2) begin
                    n_raw++;
                    if (ld_cnt < 2112) ld_cnt++;
                end
                if (op == 8'h1f && nbyte == 2 && fa == 8'hb0) cfg = sh;
                if (op == 8'h1f && nbyte == 2 && fa == 8'ha0) prot = sh;
                // id or status after the address byte
                if ((op == 8'h0f || op == 8'h9f) && nbyte == 1)
                    tx = (op == 8'h9f) ? ID_SEQ : {5{6'h00, write_enable_latch, $realtime < busy_end}};
                if ((op == 8'h10 || op == 8'hd8) && nbyte == 3 && write_enable_latch) begin
                    row[7:0] = sh;
                    write_enable_latch = 1'b0;
                    busy_end = $realtime + BUSY_NS;
                    if (op == 8'hd8 && !cfg[6]) erase_row = row;
                    if (op == 8'hd8 && !cfg[6]) n_erase++;
                    if (op == 8'h10 && !(cfg[6] && otp_lock)) begin
                        exec_row = row;
                        n_exec++;
                        otp_lock = otp_lock | (cfg[7] & cfg[6]);
                    end
                end
                nbyte++;
            end
        end
    end
    // ==========================================================
    // output on sck fall; a released line shows the inverse
    always @(negedge sck or posedge cs_n) begin
        if (cs_n || !pause_n) miso = ~miso;
        else if (nbyte >= 2 && (op == 8'h0f || op == 8'h9f)) begin
            miso = tx[39];
            tx = {tx[38:0], tx[39]};
        end
    end
endmodule : nand_flash_model

// ### spi_nand_program_erase_otp_bench.sv
// Purpose: self-checking bench for the serial nand host sequencer
// Assumes: register port and codes of the host package
// Notes:   power-up wait shortened to 20 cycles
`timescale 1ns/1ps
module spi_nand_program_erase_otp_bench;
    localparam logic [39:0] ID_EXP = 40'h5aa53c3c3c; // arbitrary identity bytes
    logic        sys_clk, rst, wr, rd, cs_n, sck, mosi, miso, pause_n, wp_n;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, d;
    int          mismatches, checked, i;
    nand_host #(.PWRUP_CYCLES(20)) DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso), .pause_n(pause_n), .wp_n(wp_n));
    nand_flash_model #(.ID_SEQ(ID_EXP)) FLASH (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso),
        .pause_n(pause_n), .wp_n(wp_n));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // access tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
            mismatches++;
        end
    endtask : check
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic wait_bit(input int b);
        for (int n = 0; n < 5000; n++) begin
            rd_reg(nand_host_pkg::A_STATUS);
            if (d[b] === 1'b1) return;
        end
        mismatches++;
        give_verdict();
    endtask : wait_bit
    task automatic run(input logic [3:0] c, input logic [3:0] a, input logic [31:0] v);
        wr_reg(a, v);
        wr_reg(nand_host_pkg::A_CMD, {28'h0, c});
        for (int n = 0; n < 8 && cs_n !== 1'b0; n++) @(posedge sys_clk);
        wait_bit(4);
    endtask : run
    // a count above a page is allowed; the host drops the excess bytes
    task automatic load(input logic [3:0] c, input logic [31:0] col, input int n);
        wr_reg(nand_host_pkg::A_COL, col);
        wr_reg(nand_host_pkg::A_CMD, {28'h0, c});
        wait_bit(5);
        for (int k = 0; k < n; k++) begin
            wait_bit(6);
            wr_reg(nand_host_pkg::A_WDATA, {24'h0, 8'ha5 + k[7:0]});
        end
        wait_bit(6);
        wr_reg(nand_host_pkg::A_CMD, {28'h0, nand_host_pkg::C_STREAM});
        wait_bit(4);
    endtask : load
    // ==========================================================
    // scenarios
    initial begin
        rst   = 1'b1;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 4'h0;
        wdata = 32'h0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 18; i++) begin
            @(negedge sys_clk);
            check({31'h0, cs_n}, 32'h1);
        end
        wait_bit(4);
        run(nand_host_pkg::C_RDID, nand_host_pkg::A_ROW, 32'h0);
        rd_reg(nand_host_pkg::A_ID_LO);
        check(d, ID_EXP[39:8]);
        rd_reg(nand_host_pkg::A_ID_HI);
        check({24'h0, d[7:0]}, {24'h0, ID_EXP[7:0]});
        load(nand_host_pkg::C_LOAD, 32'h123, 3);
        check({20'h0, FLASH.ld_col}, 32'h123);
        check(32'(FLASH.ld_cnt), 32'h3);
        run(nand_host_pkg::C_EXEC, nand_host_pkg::A_ROW, 32'h1234);
        check({16'h0, FLASH.exec_row}, 32'h1234);
        check({31'h0, $realtime >= FLASH.busy_end}, 32'h1);
        run(nand_host_pkg::C_ERASE, nand_host_pkg::A_ROW, 32'h0040);
        check({16'h0, FLASH.erase_row}, 32'h0040);
        check({31'h0, $realtime >= FLASH.busy_end}, 32'h1);
        load(nand_host_pkg::C_LOADR, 32'h800, 1);
        check({20'h0, FLASH.ld_col}, 32'h800);
        run(nand_host_pkg::C_OTPEN, nand_host_pkg::A_ROW, 32'h2);
        check({16'h0, FLASH.prot, FLASH.cfg}, 32'h0050);
        load(nand_host_pkg::C_LOAD, 32'h0, 1);
        run(nand_host_pkg::C_EXEC, nand_host_pkg::A_ROW, 32'h2);
        check(32'(FLASH.n_exec), 32'h2);
        run(nand_host_pkg::C_OTPLCK, nand_host_pkg::A_ROW, 32'h3);
        check({24'h0, FLASH.cfg}, 32'hd0);
        // locked area takes neither a program nor an erase
        run(nand_host_pkg::C_EXEC, nand_host_pkg::A_ROW, 32'h3);
        run(nand_host_pkg::C_ERASE, nand_host_pkg::A_ROW, 32'h3);
        check(32'(FLASH.n_exec + FLASH.n_erase), 32'h4);
        run(nand_host_pkg::C_OTPOFF, nand_host_pkg::A_ROW, 32'h0);
        check({24'h0, FLASH.cfg}, 32'h10);
        run(nand_host_pkg::C_OTPEN, nand_host_pkg::A_CFG, 32'h0);
        check({24'h0, FLASH.cfg}, 32'h40);
        run(nand_host_pkg::C_OTPOFF, nand_host_pkg::A_CFG, 32'h1);
        rd_reg(4'hf);
        check(d, 32'h0);
        load(nand_host_pkg::C_LOAD, 32'h0, 2113);
        check(32'(FLASH.n_raw), 32'd2112);
        give_verdict();
    end
endmodule : spi_nand_program_erase_otp_bench
